// ==== core/wionr_node.v ====
// Register map, slave-ID handling and storage/sleep control of a wireless I/O node.
// Assumes a serial front end that delivers one decoded single-register request per pulse.
`timescale 1ns/1ps
`default_nettype none
`include "wionr_defs.vh"
module wionr_node #(
    parameter [39:0] STORAGE_HOLD_CYCLES = `WIONR_STORAGE_HOLD_S * `WIONR_CLK_HZ,
    parameter [39:0] DISPLAY_LINGER_CYCLES = `WIONR_DISPLAY_LINGER_S * `WIONR_CLK_HZ,
    parameter [39:0] SLEEP_AFTER_CYCLES = `WIONR_SLEEP_AFTER_S * `WIONR_CLK_HZ,
    parameter [39:0] BLINK_HALF_CYCLES = `WIONR_BLINK_HALF_MS * `WIONR_CLK_HZ / `WIONR_MS_PER_S,
    parameter STORAGE_AT_RESET = 0
) (
    input wire clk,
    input wire rstn,
    input wire [3:0] dial_tens,
    input wire [3:0] dial_units,
    input wire transparent_mode,
    input wire button_one_n,
    input wire button_two_n,
    input wire discrete_input_one,
    input wire discrete_input_two,
    input wire discrete_input_three,
    input wire discrete_input_four,
    input wire pulse_counter_input,
    input wire sample_strobe,
    input wire [15:0] current_loop_input_one,
    input wire [15:0] current_loop_input_three,
    input wire [15:0] thermistor_input,
    input wire req_valid,
    input wire [7:0] req_slave_id,
    input wire [7:0] req_function,
    input wire [15:0] req_address,
    input wire [15:0] req_wdata,
    output reg rsp_valid_reg,
    output reg [7:0] rsp_exception_reg,
    output reg [15:0] rsp_rdata_reg,
    output reg forward_wireless_reg,
    output reg [7:0] slave_id_reg,
    output reg slave_id_valid_reg,
    output reg sink_output_one_reg,
    output reg sink_output_two_reg,
    output reg [15:0] switched_supply_three_reg,
    output reg [15:0] switched_supply_four_reg,
    output reg radio_enable_reg,
    output reg led_blink_reg,
    output reg display_on_reg
);
    reg [13:0] pin_meta_reg;
    reg [13:0] pin_sync_reg;
    reg pulse_prev_reg;
    reg [31:0] pulse_count_reg;
    reg [15:0] count_lower_snap_reg;
    reg [15:0] loop_one_reg;
    reg [15:0] loop_three_reg;
    reg [15:0] temperature_reg;
    reg storage_reg;
    reg hold_spent_reg;
    reg sleep_reg;
    reg button_prev_reg;
    reg [39:0] blink_count_reg;

    wire [3:0] tens_s = pin_sync_reg[3:0];
    wire [3:0] units_s = pin_sync_reg[7:4];
    wire transparent_s = pin_sync_reg[8];
    wire btn_one_s = ~pin_sync_reg[9];
    wire btn_two_s = ~pin_sync_reg[10];
    wire any_button = btn_one_s | btn_two_s;
    wire button_press = any_button & ~button_prev_reg;

    wire [7:0] dial_id = tens_s * `WIONR_DIAL_TENS_WEIGHT + {4'h0, units_s};
    wire id_ok = (units_s < 4'ha) && (dial_id >= `WIONR_ID_LEGAL_MIN) && (dial_id <= `WIONR_ID_LEGAL_MAX);
    wire access_ok = ~transparent_s & slave_id_valid_reg;
    wire is_local_id = (req_slave_id >= `WIONR_ID_LOCAL_MIN) && (req_slave_id <= `WIONR_ID_LOCAL_MAX);
    wire for_me = req_valid && access_ok && radio_enable_reg && (req_slave_id == slave_id_reg);
    wire [15:0] reg_num = req_address + `WIONR_ADDR_TO_NUM;
    wire is_read = (req_function == `WIONR_FC_READ_HOLD);
    wire is_write = (req_function == `WIONR_FC_WRITE_HOLD);

    wire hold_done;
    wire linger_done;
    wire sleep_done;

    // Discrete pins two to four share the pin synchroniser; pin one has its own.
    wire [3:1] disc_now = {pin_sync_reg[13], pin_sync_reg[12], pin_sync_reg[11]};

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_meta_reg <= 14'h0600;
            pin_sync_reg <= 14'h0600;
        end
        else
        begin
            pin_meta_reg <= {discrete_input_four, discrete_input_three, discrete_input_two,
                             button_two_n, button_one_n, transparent_mode, dial_units, dial_tens};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    reg disc_one_meta_reg;
    reg disc_one_sync_reg;
    reg pulse_meta_reg;
    reg pulse_sync_reg;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            disc_one_meta_reg <= 1'b0;
            disc_one_sync_reg <= 1'b0;
            pulse_meta_reg <= 1'b0;
            pulse_sync_reg <= 1'b0;
            pulse_prev_reg <= 1'b0;
            pulse_count_reg <= 32'h00000000;
            loop_one_reg <= 16'h0000;
            loop_three_reg <= 16'h0000;
            temperature_reg <= 16'h0000;
            slave_id_reg <= 8'h00;
            slave_id_valid_reg <= 1'b0;
        end
        else
        begin
            disc_one_meta_reg <= discrete_input_one;
            disc_one_sync_reg <= disc_one_meta_reg;
            pulse_meta_reg <= pulse_counter_input;
            pulse_sync_reg <= pulse_meta_reg;
            pulse_prev_reg <= pulse_sync_reg;
            if (pulse_sync_reg && !pulse_prev_reg)
                pulse_count_reg <= pulse_count_reg + 32'h00000001;
            if (sample_strobe)
            begin
                loop_one_reg <= current_loop_input_one;
                loop_three_reg <= current_loop_input_three;
                temperature_reg <= thermistor_input;
            end
            slave_id_reg <= id_ok ? dial_id : 8'h00;
            slave_id_valid_reg <= id_ok;
        end
    end

    // Register access; one answer per request addressed to this node outside transparent mode and storage.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rsp_valid_reg <= 1'b0;
            rsp_exception_reg <= `WIONR_EXC_NONE;
            rsp_rdata_reg <= 16'h0000;
            forward_wireless_reg <= 1'b0;
            count_lower_snap_reg <= 16'h0000;
            sink_output_one_reg <= 1'b0;
            sink_output_two_reg <= 1'b0;
            switched_supply_three_reg <= 16'h0000;
            switched_supply_four_reg <= 16'h0000;
        end
        else
        begin
            rsp_valid_reg <= for_me;
            forward_wireless_reg <= req_valid && access_ok && radio_enable_reg && !is_local_id
                                    && (req_slave_id != slave_id_reg);
            if (for_me)
            begin
                rsp_exception_reg <= `WIONR_EXC_NONE;
                rsp_rdata_reg <= 16'h0000;
                if (!is_read && !is_write)
                    rsp_exception_reg <= `WIONR_EXC_FUNCTION;
                else
                begin
                    case (reg_num)
                        `WIONR_REG_DISC_IN_ONE: rsp_rdata_reg <= {15'h0000, disc_one_sync_reg};
                        `WIONR_REG_DISC_IN_TWO: rsp_rdata_reg <= {15'h0000, disc_now[1]};
                        `WIONR_REG_DISC_IN_THREE: rsp_rdata_reg <= {15'h0000, disc_now[2]};
                        `WIONR_REG_DISC_IN_FOUR: rsp_rdata_reg <= {15'h0000, disc_now[3]};
                        `WIONR_REG_LOOP_IN_ONE: rsp_rdata_reg <= loop_one_reg;
                        `WIONR_REG_LOOP_IN_THREE: rsp_rdata_reg <= loop_three_reg;
                        `WIONR_REG_TEMPERATURE: rsp_rdata_reg <= temperature_reg;
                        `WIONR_REG_COUNT_UPPER:
                        begin
                            rsp_rdata_reg <= pulse_count_reg[31:16];
                            if (is_read)
                                count_lower_snap_reg <= pulse_count_reg[15:0];
                        end
                        `WIONR_REG_COUNT_LOWER: rsp_rdata_reg <= count_lower_snap_reg;
                        `WIONR_REG_SINK_OUT_ONE:
                        begin
                            if (is_write)
                                sink_output_one_reg <= req_wdata[0];
                            rsp_rdata_reg <= is_write ? {15'h0000, req_wdata[0]} : {15'h0000, sink_output_one_reg};
                        end
                        `WIONR_REG_SINK_OUT_TWO:
                        begin
                            if (is_write)
                                sink_output_two_reg <= req_wdata[0];
                            rsp_rdata_reg <= is_write ? {15'h0000, req_wdata[0]} : {15'h0000, sink_output_two_reg};
                        end
                        `WIONR_REG_SUPPLY_THREE:
                        begin
                            if (is_write)
                                switched_supply_three_reg <= req_wdata;
                            rsp_rdata_reg <= is_write ? req_wdata : switched_supply_three_reg;
                        end
                        `WIONR_REG_SUPPLY_FOUR:
                        begin
                            if (is_write)
                                switched_supply_four_reg <= req_wdata;
                            rsp_rdata_reg <= is_write ? req_wdata : switched_supply_four_reg;
                        end
                        default: rsp_exception_reg <= `WIONR_EXC_ADDRESS;
                    endcase
                end
            end
        end
    end

    wionr_timer #(.WIDTH(40), .LIMIT(STORAGE_HOLD_CYCLES)) u_hold (
        .clk(clk),
        .rstn(rstn),
        .clear(~btn_one_s),
        .run(btn_one_s),
        .done(hold_done)
    );

    wionr_timer #(.WIDTH(40), .LIMIT(DISPLAY_LINGER_CYCLES)) u_linger (
        .clk(clk),
        .rstn(rstn),
        .clear(~storage_reg),
        .run(storage_reg),
        .done(linger_done)
    );

    wionr_timer #(.WIDTH(40), .LIMIT(SLEEP_AFTER_CYCLES)) u_sleep (
        .clk(clk),
        .rstn(rstn),
        .clear(storage_reg | button_press),
        .run(~sleep_reg),
        .done(sleep_done)
    );

    // One toggle per hold; the button must be released before the next.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            storage_reg <= (STORAGE_AT_RESET != 0);
            hold_spent_reg <= 1'b0;
            sleep_reg <= 1'b0;
            button_prev_reg <= 1'b0;
            radio_enable_reg <= (STORAGE_AT_RESET == 0);
            blink_count_reg <= 40'h0000000000;
            led_blink_reg <= 1'b0;
            display_on_reg <= (STORAGE_AT_RESET == 0);
        end
        else
        begin
            button_prev_reg <= any_button;
            if (!btn_one_s)
                hold_spent_reg <= 1'b0;
            else if (hold_done && !hold_spent_reg)
            begin
                hold_spent_reg <= 1'b1;
                storage_reg <= ~storage_reg;
            end
            radio_enable_reg <= ~storage_reg;
            if (storage_reg || button_press)
                sleep_reg <= 1'b0;
            else if (sleep_done)
                sleep_reg <= 1'b1;
            if (storage_reg || blink_count_reg >= BLINK_HALF_CYCLES - 40'h0000000001)
                blink_count_reg <= 40'h0000000000;
            else
                blink_count_reg <= blink_count_reg + 40'h0000000001;
            if (storage_reg)
                led_blink_reg <= 1'b0;
            else if (blink_count_reg >= BLINK_HALF_CYCLES - 40'h0000000001)
                led_blink_reg <= ~led_blink_reg;
            display_on_reg <= storage_reg ? ~linger_done : ~sleep_reg;
        end
    end
endmodule
`default_nettype wire

// ==== core/wionr_defs.vh ====
// Constants of the wireless I/O node register logic.
// Assumes inclusion by bare name from the design files under core/.
`ifndef WIONR_DEFS_VH
`define WIONR_DEFS_VH

// Holding register numbers (one-based); the protocol address is the number minus one.
`define WIONR_REG_DISC_IN_ONE 16'h0001
`define WIONR_REG_DISC_IN_TWO 16'h0002
`define WIONR_REG_DISC_IN_THREE 16'h0003
`define WIONR_REG_DISC_IN_FOUR 16'h0004
`define WIONR_REG_LOOP_IN_ONE 16'h0005
`define WIONR_REG_LOOP_IN_THREE 16'h0007
`define WIONR_REG_TEMPERATURE 16'h0008
`define WIONR_REG_COUNT_UPPER 16'h0009
`define WIONR_REG_COUNT_LOWER 16'h000a
`define WIONR_REG_SINK_OUT_ONE 16'h01f5
`define WIONR_REG_SINK_OUT_TWO 16'h01f6
`define WIONR_REG_SUPPLY_THREE 16'h01f9
`define WIONR_REG_SUPPLY_FOUR 16'h01fa
`define WIONR_ADDR_TO_NUM 16'h0001

// Function codes and exception codes.
`define WIONR_FC_READ_HOLD 8'h03
`define WIONR_FC_WRITE_HOLD 8'h06
`define WIONR_EXC_NONE 8'h00
`define WIONR_EXC_FUNCTION 8'h01
`define WIONR_EXC_ADDRESS 8'h02

// Slave identifier ranges.
`define WIONR_ID_LOCAL_MIN 8'h01
`define WIONR_ID_LOCAL_MAX 8'h0a
`define WIONR_ID_LEGAL_MIN 8'h01
`define WIONR_ID_LEGAL_MAX 8'h3c
`define WIONR_DIAL_TENS_WEIGHT 8'h0a

// Times in their own units and the clock rate.
`define WIONR_CLK_HZ 40'd125000000
`define WIONR_STORAGE_HOLD_S 40'd5
`define WIONR_DISPLAY_LINGER_S 40'd60
`define WIONR_SLEEP_AFTER_S 40'd900
`define WIONR_BLINK_HALF_MS 40'd500
`define WIONR_MS_PER_S 40'd1000

`endif

// ==== core/wionr_timer.v ====
// Saturating elapsed-time counter with a reached flag.
// Assumes clear and run come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wionr_timer #(
    parameter WIDTH = 40,
    parameter [WIDTH-1:0] LIMIT = {{(WIDTH-1){1'b0}}, 1'b1}
) (
    input wire clk,
    input wire rstn,
    input wire clear,
    input wire run,
    output wire done
);
    reg [WIDTH-1:0] count_reg;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            count_reg <= {WIDTH{1'b0}};
        else if (clear)
            count_reg <= {WIDTH{1'b0}};
        else if (run && count_reg != LIMIT)
            count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    assign done = (count_reg == LIMIT);
endmodule
`default_nettype wire

// ==== dv/wionr_host.sv ====
// Host model: polls the node with decoded single-register requests.
// Assumes the node takes a request on the rising edge and answers one cycle later.
`timescale 1ns/1ps
`default_nettype none
module wionr_host (
    input wire logic clk,
    output logic req_valid,
    output logic [7:0] req_slave_id,
    output logic [7:0] req_function,
    output logic [15:0] req_address,
    output logic [15:0] req_wdata,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_exception,
    input wire logic [15:0] rsp_rdata,
    input wire logic forward
);
    logic got_rsp;
    logic got_fwd;
    logic [7:0] got_exc;
    logic [15:0] got_data;
    initial
    begin
        req_valid = 1'b0;
        req_slave_id = 8'h00;
        req_function = 8'h00;
        req_address = 16'h0000;
        req_wdata = 16'h0000;
    end
    task automatic xfer(input logic [7:0] id, input logic [7:0] fc, input logic [15:0] num, input logic [15:0] wd);
        @(negedge clk);
        req_valid = 1'b1;
        req_slave_id = id;
        req_function = fc;
        req_address = num - 16'h0001;
        req_wdata = wd;
        @(negedge clk);
        got_rsp = rsp_valid;
        got_fwd = forward;
        got_exc = rsp_exception;
        got_data = rsp_rdata;
        req_valid = 1'b0;
        // The released address and write data toggle so that stale values are never mistaken for live ones.
        req_address = ~req_address;
        req_wdata = ~req_wdata;
    endtask
endmodule
`default_nettype wire

// ==== dv/wionr_monitor.sv ====
// Checker of the node's request, relay and storage behaviour.
// Assumes it is bound to wionr_node and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module wionr_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic transparent_mode,
    input wire logic req_valid,
    input wire logic [7:0] req_slave_id,
    input wire logic [7:0] req_function,
    input wire logic [15:0] req_address,
    input wire logic [15:0] req_wdata,
    input wire logic rsp_valid_reg,
    input wire logic [7:0] rsp_exception_reg,
    input wire logic forward_wireless_reg,
    input wire logic [7:0] slave_id_reg,
    input wire logic slave_id_valid_reg,
    input wire logic sink_output_one_reg,
    input wire logic radio_enable_reg,
    input wire logic led_blink_reg
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic ok;
    logic own;
    logic [1:0] mode_pipe;
    // The node reads the mode pin through two flip-flops, so its decision lags the pin by two cycles.
    always @(posedge clk)
        mode_pipe <= {mode_pipe[0], transparent_mode};
    assign ok = !mode_pipe[1] && slave_id_valid_reg && radio_enable_reg;
    assign own = req_slave_id == slave_id_reg;
    a_own_answer: assert property (req_valid && ok && own |=> rsp_valid_reg) else $error("own request unanswered");
    a_local_kept: assert property (req_valid && req_slave_id inside {[8'h01:8'h0a]} |=> !forward_wireless_reg) else $error("local id relayed");
    a_remote_relay: assert property (req_valid && ok && req_slave_id > 8'h0a && !own |=> forward_wireless_reg && !rsp_valid_reg) else $error("remote id not relayed");
    a_bad_function: assert property (req_valid && ok && own && req_function != 8'h03 && req_function != 8'h06 |=> rsp_exception_reg == 8'h01) else $error("bad function accepted");
    a_modbus_only: assert property (transparent_mode [*5] |=> !rsp_valid_reg && !forward_wireless_reg) else $error("access in transparent mode");
    a_id_range: assert property (slave_id_valid_reg |-> slave_id_reg >= 8'h01 && slave_id_reg <= 8'h3c) else $error("id out of range");
    a_storage_dark: assert property (!radio_enable_reg |-> !led_blink_reg) else $error("led blinks in storage");
    a_storage_silent: assert property (!radio_enable_reg |=> !rsp_valid_reg && !forward_wireless_reg) else $error("radio active in storage");
    a_sink_write: assert property (req_valid && ok && own && req_function == 8'h06 && req_address == 16'h01f4 |=> sink_output_one_reg == $past(req_wdata[0])) else $error("output not written");
    c_relay: cover property (forward_wireless_reg);
    c_bad_address: cover property (rsp_valid_reg && rsp_exception_reg == 8'h02);
    c_storage: cover property ($fell(radio_enable_reg));
endmodule
bind wionr_node wionr_monitor u_mon (.clk(clk), .rstn(rstn), .transparent_mode(transparent_mode), .req_valid(req_valid),
    .req_slave_id(req_slave_id), .req_function(req_function), .req_address(req_address), .req_wdata(req_wdata),
    .rsp_valid_reg(rsp_valid_reg), .rsp_exception_reg(rsp_exception_reg), .forward_wireless_reg(forward_wireless_reg),
    .slave_id_reg(slave_id_reg), .slave_id_valid_reg(slave_id_valid_reg), .sink_output_one_reg(sink_output_one_reg),
    .radio_enable_reg(radio_enable_reg), .led_blink_reg(led_blink_reg));
`default_nettype wire

// ==== dv/wireless_io_node_register_map_bench.sv ====
// Self-checking bench of the node: ids, register map, storage and sleep.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module wireless_io_node_register_map_bench;
    logic clk, rstn, tm, b1_n, b2_n, pc, ss;
    logic [3:0] dt, du, di;
    logic [15:0] l1, l3, th;
    logic rq, rv, fw, sv, s1, s2, re, lb, dn;
    logic [7:0] rid, rfc, rex, sid;
    logic [15:0] ra, rw, rd, sp3, sp4;
    int failures = 0, samples_checked = 0, cycles = 0;
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    wionr_node #(.STORAGE_HOLD_CYCLES(40'd20), .DISPLAY_LINGER_CYCLES(40'd30), .SLEEP_AFTER_CYCLES(40'd50),
        .BLINK_HALF_CYCLES(40'd4)) u_dut (.clk(clk), .rstn(rstn), .dial_tens(dt), .dial_units(du),
        .transparent_mode(tm), .button_one_n(b1_n), .button_two_n(b2_n), .discrete_input_one(di[0]),
        .discrete_input_two(di[1]), .discrete_input_three(di[2]), .discrete_input_four(di[3]),
        .pulse_counter_input(pc), .sample_strobe(ss), .current_loop_input_one(l1), .current_loop_input_three(l3),
        .thermistor_input(th), .req_valid(rq), .req_slave_id(rid), .req_function(rfc), .req_address(ra),
        .req_wdata(rw), .rsp_valid_reg(rv), .rsp_exception_reg(rex), .rsp_rdata_reg(rd), .forward_wireless_reg(fw),
        .slave_id_reg(sid), .slave_id_valid_reg(sv), .sink_output_one_reg(s1), .sink_output_two_reg(s2),
        .switched_supply_three_reg(sp3), .switched_supply_four_reg(sp4), .radio_enable_reg(re),
        .led_blink_reg(lb), .display_on_reg(dn));
    wionr_host u_host (.clk(clk), .req_valid(rq), .req_slave_id(rid), .req_function(rfc), .req_address(ra),
        .req_wdata(rw), .rsp_valid(rv), .rsp_exception(rex), .rsp_rdata(rd), .forward(fw));
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            complete_run();
        end
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic req(input logic [7:0] fc, input logic [15:0] num, input logic [15:0] wd, input logic [7:0] exc,
        input logic [15:0] exp);
        u_host.xfer(8'h0c, fc, num, wd);
        `CHK({u_host.got_rsp, u_host.got_exc, u_host.got_data}, {1'b1, exc, exp})
    endtask
    task automatic t_ids();
        dt = 4'h6;
        du = 4'h1;
        idle(5);
        `CHK(sv, 1'b0)
        du = 4'ha;
        dt = 4'h0;
        idle(5);
        `CHK(sv, 1'b0)
        dt = 4'h1;
        du = 4'h2;
        idle(5);
        `CHK({sv, sid}, {1'b1, 8'h0c})
        u_host.xfer(8'h07, 8'h03, 16'h0001, 16'h0000);
        `CHK({u_host.got_rsp, u_host.got_fwd}, 2'b00)
        u_host.xfer(8'h1e, 8'h03, 16'h0001, 16'h0000);
        `CHK({u_host.got_rsp, u_host.got_fwd}, 2'b01)
        $display("test ids done");
    endtask
    task automatic t_inputs();
        di = 4'b1101;
        @(negedge clk);
        ss = 1'b1;
        l1 = 16'h1234;
        l3 = 16'hbeef;
        th = 16'h8001;
        @(negedge clk);
        ss = 1'b0;
        idle(4);
        req(8'h03, 16'h0001, 16'h0000, 8'h00, 16'h0001);
        req(8'h03, 16'h0002, 16'h0000, 8'h00, 16'h0000);
        req(8'h03, 16'h0003, 16'h0000, 8'h00, 16'h0001);
        req(8'h03, 16'h0004, 16'h0000, 8'h00, 16'h0001);
        req(8'h03, 16'h0005, 16'h0000, 8'h00, 16'h1234);
        req(8'h03, 16'h0007, 16'h0000, 8'h00, 16'hbeef);
        req(8'h03, 16'h0008, 16'h0000, 8'h00, 16'h8001);
        req(8'h06, 16'h0001, 16'h0000, 8'h00, 16'h0001);
        req(8'h03, 16'h0001, 16'h0000, 8'h00, 16'h0001);
        req(8'h03, 16'h0006, 16'h0000, 8'h02, 16'h0000);
        req(8'h04, 16'h0001, 16'h0000, 8'h01, 16'h0000);
        $display("test inputs done");
    endtask
    task automatic t_counter();
        req(8'h03, 16'h000a, 16'h0000, 8'h00, 16'h0000);
        repeat (5)
        begin
            pc = 1'b1;
            idle(3);
            pc = 1'b0;
            idle(3);
        end
        req(8'h03, 16'h0009, 16'h0000, 8'h00, 16'h0000);
        req(8'h03, 16'h000a, 16'h0000, 8'h00, 16'h0005);
        $display("test counter done");
    endtask
    task automatic t_outputs();
        req(8'h06, 16'h01f5, 16'h0001, 8'h00, 16'h0001);
        req(8'h06, 16'h01f6, 16'h0001, 8'h00, 16'h0001);
        req(8'h06, 16'h01f9, 16'ha5c3, 8'h00, 16'ha5c3);
        req(8'h06, 16'h01fa, 16'h3c5a, 8'h00, 16'h3c5a);
        `CHK({s1, s2, sp3, sp4}, {2'b11, 16'ha5c3, 16'h3c5a})
        req(8'h06, 16'h01f5, 16'h0000, 8'h00, 16'h0000);
        `CHK({s1, s2}, 2'b01)
        tm = 1'b1;
        idle(5);
        u_host.xfer(8'h0c, 8'h03, 16'h01f6, 16'h0000);
        `CHK({u_host.got_rsp, u_host.got_fwd}, 2'b00)
        tm = 1'b0;
        idle(5);
        $display("test outputs done");
    endtask
    task automatic t_storage();
        b1_n = 1'b0;
        idle(30);
        b1_n = 1'b1;
        idle(5);
        `CHK({re, lb}, 2'b00)
        u_host.xfer(8'h0c, 8'h03, 16'h0001, 16'h0000);
        `CHK({u_host.got_rsp, u_host.got_fwd}, 2'b00)
        idle(40);
        `CHK({re, lb, dn}, 3'b000)
        b1_n = 1'b0;
        idle(30);
        b1_n = 1'b1;
        idle(5);
        `CHK(re, 1'b1)
        req(8'h03, 16'h0002, 16'h0000, 8'h00, 16'h0000);
        $display("test storage done");
    endtask
    task automatic t_sleep();
        logic prev;
        b2_n = 1'b0;
        idle(4);
        b2_n = 1'b1;
        idle(4);
        `CHK(dn, 1'b1)
        idle(70);
        `CHK(dn, 1'b0)
        req(8'h03, 16'h0001, 16'h0000, 8'h00, 16'h0001);
        b2_n = 1'b0;
        idle(4);
        `CHK(dn, 1'b1)
        b2_n = 1'b1;
        prev = lb;
        idle(4);
        `CHK(lb, !prev)
        $display("test sleep done");
    endtask
    initial
    begin
        {rstn, tm, pc, ss, di, dt, du, l1, l3, th} = '0;
        b1_n = 1'b1;
        b2_n = 1'b1;
        idle(16);
        rstn = 1'b1;
        idle(4);
        t_ids();
        t_inputs();
        t_counter();
        t_outputs();
        t_storage();
        t_sleep();
        complete_run();
    end
endmodule
`default_nettype wire
